// ### pkg/usart_mode_pkg.sv
package usart_mode_pkg;

  // register byte offsets
  localparam logic [7:0] MODE_OFFSET   = 8'h14;
  localparam logic [7:0] GUARD_OFFSET  = 8'h18;
  localparam logic [7:0] UNIT_OFFSET   = 8'h1C;
  localparam logic [7:0] STATUS_OFFSET = 8'h20;
  localparam logic [7:0] MASK_OFFSET   = 8'h24;

  // mode_and_flow_control field positions
  localparam int ERROR_IRQ_ENABLE_BIT       = 0;
  localparam int INFRARED_ENABLE_BIT        = 1;
  localparam int INFRARED_LOW_POWER_BIT     = 2;
  localparam int HALF_DUPLEX_ENABLE_BIT     = 3;
  localparam int CARD_PARITY_NAK_BIT        = 4;
  localparam int CARD_MODE_ENABLE_BIT       = 5;
  localparam int RX_DMA_REQUEST_ENABLE_BIT  = 6;
  localparam int TX_DMA_REQUEST_ENABLE_BIT  = 7;
  localparam int RTS_FLOW_ENABLE_BIT        = 8;
  localparam int CTS_FLOW_ENABLE_BIT        = 9;
  localparam int CTS_IRQ_ENABLE_BIT         = 10;
  localparam int SINGLE_SAMPLE_BIT          = 11;
  localparam int MODE_WIDTH                 = 12;

  // guard_time_and_prescaler fields
  localparam int PRESCALER_LSB   = 0;
  localparam int PRESCALER_WIDTH = 8;
  localparam int CARD_PSC_WIDTH  = 5;
  localparam int GUARD_LSB       = 8;
  localparam int GUARD_WIDTH     = 8;
  localparam int GUARD_REG_WIDTH = 16;

  // unit control register
  localparam int UNIT_ENABLE_BIT = 0;

  // interrupt status / mask layout
  localparam int ST_FRAMING    = 0;
  localparam int ST_OVERRUN    = 1;
  localparam int ST_NOISE      = 2;
  localparam int ST_CTS_CHANGE = 3;
  localparam int ST_TX_DONE    = 4;
  localparam int STATUS_WIDTH  = 5;

  // reset values
  localparam logic [MODE_WIDTH-1:0]      MODE_RESET   = 12'h000;
  localparam logic [GUARD_REG_WIDTH-1:0] GUARD_RESET  = 16'h0000;
  localparam logic                       UNIT_RESET   = 1'b0;
  localparam logic [STATUS_WIDTH-1:0]    STATUS_RESET = 5'h00;
  localparam logic [STATUS_WIDTH-1:0]    MASK_RESET   = 5'h00;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_GUARD = 3'b100
  } tx_state_e;

endpackage

// ### verilog/prescale_divider.sv
`timescale 1ns/1ps
`default_nettype none

// one-cycle tick every divisor_i clocks; divisor 0 stops it
module prescale_divider (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       run_i,
  input  wire logic [7:0] divisor_i,
  output logic            tick_o
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_tick;

  always_comb begin
    next_count = 8'h00;
    next_tick  = 1'b0;
    if (run_i && divisor_i != 8'h00) begin
      if (count >= divisor_i - 8'h01) begin
        next_tick = 1'b1;
      end else begin
        next_count = count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      count  <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule // prescale_divider

`default_nettype wire

// ### verilog/usart_mode_flow_guard_control.sv
// How it works
// - bits 6/7 enable DMA requests; errors interrupt with bit 0 and bit 6.
// - bit 1 infrared, bit 2 low-power select, bit 3 half-duplex.
// - bit 5 smartcard; bit 4 sends NAK on received parity error.
// - with bit 8, request-to-send low only while receive buffer has room.
// - with bit 9, transmit only while clear-to-send input is low.
// - clear-to-send rising mid-character lets that character finish.
// - data written while clear-to-send high waits until it goes low.
// - bit 10 lets the clear-to-send change flag interrupt.
// - bit 11 chooses single sample and then ignores noise errors.
// - low-power infrared clock divides by all eight prescaler bits.
// - smartcard clock divides by twice the low five prescaler bits.
// - smartcard waits guard time in baud periods before completion.
// - unit disabled stops the divider and the outputs, except single_sample_o and an irq_o from already set status.
`timescale 1ns/1ps
`default_nettype none

module usart_mode_flow_guard_control (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        framing_error_i,
  input  wire logic        overrun_error_i,
  input  wire logic        noise_error_i,
  input  wire logic        parity_error_i,
  input  wire logic        rx_data_ready_i,
  input  wire logic        rx_room_i,
  input  wire logic        tx_empty_i,
  input  wire logic        tx_write_i,
  input  wire logic        tx_char_done_i,
  input  wire logic        baud_tick_i,
  input  wire logic        cts_n_i,
  output logic             irq_o,
  output logic             rx_dma_req_o,
  output logic             tx_dma_req_o,
  output logic             rts_n_o,
  output logic             tx_load_o,
  output logic             tx_complete_o,
  output logic             card_nak_o,
  output logic             infrared_enable_o,
  output logic             infrared_low_power_o,
  output logic             half_duplex_o,
  output logic             card_mode_o,
  output logic             single_sample_o,
  output logic             low_power_tick_o,
  output logic             card_clk_o,
  output logic             unit_active_o
);

  localparam int MW = usart_mode_pkg::MODE_WIDTH;
  localparam int SW = usart_mode_pkg::STATUS_WIDTH;

  // ---------------- registers ----------------
  logic [MW-1:0]                             mode;
  logic [usart_mode_pkg::GUARD_REG_WIDTH-1:0] guard_psc;
  logic                                      unit_enable;
  logic [SW-1:0]                             status;
  logic [SW-1:0]                             mask;
  logic [MW-1:0]                             next_mode;
  logic [usart_mode_pkg::GUARD_REG_WIDTH-1:0] next_guard_psc;
  logic                                      next_unit_enable;
  logic [SW-1:0]                             next_status;
  logic [SW-1:0]                             next_mask;
  logic [31:0]                               next_rdata;
  logic [SW-1:0]                             status_set;
  logic [SW-1:0]                             irq_gate;
  logic                                      next_irq;
  logic                                      cts_prev;

  logic [7:0] prescaler;
  logic [7:0] guard_time;
  logic       card_mode;
  logic       cts_flow;

  assign prescaler  = guard_psc[usart_mode_pkg::PRESCALER_LSB +:
                                usart_mode_pkg::PRESCALER_WIDTH];
  assign guard_time = guard_psc[usart_mode_pkg::GUARD_LSB +:
                                usart_mode_pkg::GUARD_WIDTH];
  assign card_mode  = mode[usart_mode_pkg::CARD_MODE_ENABLE_BIT];
  assign cts_flow   = mode[usart_mode_pkg::CTS_FLOW_ENABLE_BIT];

  always_comb begin
    next_mode        = mode;
    next_guard_psc   = guard_psc;
    next_unit_enable = unit_enable;
    next_mask        = mask;
    next_rdata       = 32'h0000_0000;
    if (wr_i) begin
      if (addr_i == usart_mode_pkg::MODE_OFFSET) begin
        next_mode = wdata_i[MW-1:0];
        // sampling method frozen while the unit runs
        if (unit_enable) begin
          next_mode[usart_mode_pkg::SINGLE_SAMPLE_BIT] =
            mode[usart_mode_pkg::SINGLE_SAMPLE_BIT];
        end
      end else if (addr_i == usart_mode_pkg::GUARD_OFFSET) begin
        next_guard_psc = wdata_i[usart_mode_pkg::GUARD_REG_WIDTH-1:0];
      end else if (addr_i == usart_mode_pkg::UNIT_OFFSET) begin
        next_unit_enable = wdata_i[usart_mode_pkg::UNIT_ENABLE_BIT];
      end else if (addr_i == usart_mode_pkg::MASK_OFFSET) begin
        next_mask = wdata_i[SW-1:0];
      end
    end
    if (rd_i) begin
      if (addr_i == usart_mode_pkg::MODE_OFFSET) begin
        next_rdata[MW-1:0] = mode;
      end else if (addr_i == usart_mode_pkg::GUARD_OFFSET) begin
        next_rdata[usart_mode_pkg::GUARD_REG_WIDTH-1:0] = guard_psc;
      end else if (addr_i == usart_mode_pkg::UNIT_OFFSET) begin
        next_rdata[usart_mode_pkg::UNIT_ENABLE_BIT] = unit_enable;
      end else if (addr_i == usart_mode_pkg::STATUS_OFFSET) begin
        next_rdata[SW-1:0] = status;
      end else if (addr_i == usart_mode_pkg::MASK_OFFSET) begin
        next_rdata[SW-1:0] = mask;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode        <= usart_mode_pkg::MODE_RESET;
      guard_psc   <= usart_mode_pkg::GUARD_RESET;
      unit_enable <= usart_mode_pkg::UNIT_RESET;
      mask        <= usart_mode_pkg::MASK_RESET;
      rdata_o     <= 32'h0000_0000;
    end else begin
      mode        <= next_mode;
      guard_psc   <= next_guard_psc;
      unit_enable <= next_unit_enable;
      mask        <= next_mask;
      rdata_o     <= next_rdata;
    end
  end

  // ---------------- transmit sequencing ----------------
  usart_mode_pkg::tx_state_e tx_state;
  usart_mode_pkg::tx_state_e next_tx_state;
  logic       tx_pending;
  logic       next_tx_pending;
  logic [7:0] guard_count;
  logic [7:0] next_guard_count;
  logic       next_tx_load;
  logic       next_tx_complete;
  logic       cts_clear;

  assign cts_clear = !cts_flow || !cts_n_i;

  always_comb begin
    next_tx_state    = tx_state;
    next_tx_pending  = tx_pending;
    next_guard_count = guard_count;
    next_tx_load     = 1'b0;
    next_tx_complete = 1'b0;
    case (tx_state)
      usart_mode_pkg::TX_IDLE: begin
        if (tx_pending && unit_enable && cts_clear) begin
          next_tx_load    = 1'b1;
          next_tx_pending = 1'b0;
          next_tx_state   = usart_mode_pkg::TX_SHIFT;
        end
      end
      usart_mode_pkg::TX_SHIFT: begin
        if (tx_char_done_i) begin
          if (card_mode && guard_time != 8'h00) begin
            next_guard_count = guard_time;
            next_tx_state    = usart_mode_pkg::TX_GUARD;
          end else begin
            next_tx_complete = 1'b1;
            next_tx_state    = usart_mode_pkg::TX_IDLE;
          end
        end
      end
      usart_mode_pkg::TX_GUARD: begin
        if (baud_tick_i) begin
          next_guard_count = guard_count - 8'h01;
          if (guard_count == 8'h01) begin
            next_tx_complete = 1'b1;
            next_tx_state    = usart_mode_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        next_tx_state = usart_mode_pkg::TX_IDLE;
      end
    endcase
    // a new write is never lost to the load of the previous one
    if (tx_write_i) begin
      next_tx_pending = 1'b1;
    end
    if (!unit_enable) begin
      next_tx_state    = usart_mode_pkg::TX_IDLE;
      next_tx_pending  = 1'b0;
      next_tx_load     = 1'b0;
      next_tx_complete = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_state      <= usart_mode_pkg::TX_IDLE;
      tx_pending    <= 1'b0;
      guard_count   <= 8'h00;
      tx_load_o     <= 1'b0;
      tx_complete_o <= 1'b0;
    end else begin
      tx_state      <= next_tx_state;
      tx_pending    <= next_tx_pending;
      guard_count   <= next_guard_count;
      tx_load_o     <= next_tx_load;
      tx_complete_o <= next_tx_complete;
    end
  end

  // ---------------- events and interrupt ----------------
  always_comb begin
    status_set = '0;
    status_set[usart_mode_pkg::ST_FRAMING] = unit_enable && framing_error_i;
    status_set[usart_mode_pkg::ST_OVERRUN] = unit_enable && overrun_error_i;
    // no noise flag in single sample
    status_set[usart_mode_pkg::ST_NOISE] = unit_enable && noise_error_i &&
      !mode[usart_mode_pkg::SINGLE_SAMPLE_BIT];
    status_set[usart_mode_pkg::ST_CTS_CHANGE] = unit_enable &&
      (cts_n_i != cts_prev);
    status_set[usart_mode_pkg::ST_TX_DONE] = next_tx_complete;
    // set wins over the read clear
    next_status = status;
    if (rd_i && addr_i == usart_mode_pkg::STATUS_OFFSET) begin
      next_status = '0;
    end
    next_status = next_status | status_set;
    irq_gate = '1;
    irq_gate[usart_mode_pkg::ST_FRAMING] =
      mode[usart_mode_pkg::ERROR_IRQ_ENABLE_BIT] &&
      mode[usart_mode_pkg::RX_DMA_REQUEST_ENABLE_BIT];
    irq_gate[usart_mode_pkg::ST_OVERRUN] =
      irq_gate[usart_mode_pkg::ST_FRAMING];
    irq_gate[usart_mode_pkg::ST_NOISE] =
      irq_gate[usart_mode_pkg::ST_FRAMING];
    irq_gate[usart_mode_pkg::ST_CTS_CHANGE] =
      mode[usart_mode_pkg::CTS_IRQ_ENABLE_BIT];
    next_irq = |(next_status & mask & irq_gate);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status   <= usart_mode_pkg::STATUS_RESET;
      cts_prev <= 1'b1;
      irq_o    <= 1'b0;
    end else begin
      status   <= next_status;
      cts_prev <= cts_n_i;
      irq_o    <= next_irq;
    end
  end

  // ---------------- prescaler clocks ----------------
  logic       div_tick;
  logic       div_run;
  logic [7:0] div_value;
  logic       lp_mode;
  logic       next_card_clk;

  assign lp_mode = mode[usart_mode_pkg::INFRARED_ENABLE_BIT] &&
                   mode[usart_mode_pkg::INFRARED_LOW_POWER_BIT];
  assign div_run = unit_enable && (card_mode || lp_mode);
  // low five bits in smartcard mode
  // all eight bits in low-power infrared
  assign div_value = card_mode ?
    {3'h0, prescaler[usart_mode_pkg::CARD_PSC_WIDTH-1:0]} : prescaler;

  prescale_divider u_divider (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .run_i     (div_run),
    .divisor_i (div_value),
    .tick_o    (div_tick)
  );

  always_comb begin
    next_card_clk = 1'b0;
    // toggle per tick gives twice the divisor
    if (div_run && card_mode) begin
      next_card_clk = div_tick ? !card_clk_o : card_clk_o;
    end
  end

  // ---------------- mode and flow outputs ----------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_dma_req_o         <= 1'b0;
      tx_dma_req_o         <= 1'b0;
      rts_n_o              <= 1'b1;
      card_nak_o           <= 1'b0;
      infrared_enable_o    <= 1'b0;
      infrared_low_power_o <= 1'b0;
      half_duplex_o        <= 1'b0;
      card_mode_o          <= 1'b0;
      single_sample_o      <= 1'b0;
      low_power_tick_o     <= 1'b0;
      card_clk_o           <= 1'b0;
      unit_active_o        <= 1'b0;
    end else begin
      rx_dma_req_o <= unit_enable && rx_data_ready_i &&
                      mode[usart_mode_pkg::RX_DMA_REQUEST_ENABLE_BIT];
      tx_dma_req_o <= unit_enable && tx_empty_i &&
                      mode[usart_mode_pkg::TX_DMA_REQUEST_ENABLE_BIT];
      rts_n_o <= !unit_enable ||
                 (mode[usart_mode_pkg::RTS_FLOW_ENABLE_BIT] && !rx_room_i);
      card_nak_o <= unit_enable && card_mode && parity_error_i &&
                    mode[usart_mode_pkg::CARD_PARITY_NAK_BIT];
      infrared_enable_o    <= unit_enable &&
                              mode[usart_mode_pkg::INFRARED_ENABLE_BIT];
      infrared_low_power_o <= unit_enable &&
                              mode[usart_mode_pkg::INFRARED_LOW_POWER_BIT];
      half_duplex_o        <= unit_enable &&
                              mode[usart_mode_pkg::HALF_DUPLEX_ENABLE_BIT];
      card_mode_o          <= unit_enable && card_mode;
      single_sample_o      <= mode[usart_mode_pkg::SINGLE_SAMPLE_BIT];
      low_power_tick_o     <= div_tick && lp_mode && !card_mode;
      card_clk_o           <= next_card_clk;
      unit_active_o        <= unit_enable;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_err_irq;
    (unit_enable && framing_error_i && mask[usart_mode_pkg::ST_FRAMING] &&
     mode[usart_mode_pkg::ERROR_IRQ_ENABLE_BIT] &&
     mode[usart_mode_pkg::RX_DMA_REQUEST_ENABLE_BIT] && !wr_i) |=> irq_o;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq missing");

  property p_card_nak;
    (unit_enable && card_mode && parity_error_i &&
     !mode[usart_mode_pkg::CARD_PARITY_NAK_BIT]) |=> !card_nak_o;
  endproperty
  a_card_nak: assert property (p_card_nak) else $error("nak while off");

  property p_rts_room;
    (unit_enable && mode[usart_mode_pkg::RTS_FLOW_ENABLE_BIT] && rx_room_i)
      |=> !rts_n_o;
  endproperty
  a_rts_room: assert property (p_rts_room) else $error("rts not low");

  property p_cts_hold;
    (tx_load_o && $past(cts_flow)) |-> !$past(cts_n_i);
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("sent while cts high");

  property p_finish_char;
    (tx_state == usart_mode_pkg::TX_SHIFT && cts_n_i && unit_enable &&
     !tx_char_done_i) |=> tx_state == usart_mode_pkg::TX_SHIFT;
  endproperty
  a_finish_char: assert property (p_finish_char) else $error("char cut");

  property p_held_write;
    (tx_write_i && unit_enable && cts_flow && cts_n_i && !wr_i)
      |=> tx_pending && !tx_load_o;
  endproperty
  a_held_write: assert property (p_held_write) else $error("write lost");

  property p_cts_irq;
    (unit_enable && cts_n_i != $past(cts_n_i) && !wr_i &&
     mode[usart_mode_pkg::CTS_IRQ_ENABLE_BIT] &&
     mask[usart_mode_pkg::ST_CTS_CHANGE]) |=> irq_o;
  endproperty
  a_cts_irq: assert property (p_cts_irq) else $error("cts irq missing");

  property p_single_noise;
    (mode[usart_mode_pkg::SINGLE_SAMPLE_BIT] &&
     !status[usart_mode_pkg::ST_NOISE]) |=> !status[usart_mode_pkg::ST_NOISE];
  endproperty
  a_single_noise: assert property (p_single_noise) else $error("noise set");

  property p_guard_done;
    (tx_state == usart_mode_pkg::TX_GUARD && guard_count == 8'h01 &&
     baud_tick_i && unit_enable) |=> tx_complete_o;
  endproperty
  a_guard_done: assert property (p_guard_done) else $error("guard end");

  property p_unit_off;
    !unit_enable |=> !tx_load_o && !card_nak_o ##1 !low_power_tick_o;
  endproperty
  a_unit_off: assert property (p_unit_off) else $error("active while off");

  property p_reserved;
    (rd_i && addr_i == usart_mode_pkg::MODE_OFFSET) |=> rdata_o[31:12] == 0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

endmodule // usart_mode_flow_guard_control

`default_nettype wire

// ### bench/remote_node_model.sv
`timescale 1ns/1ps
`default_nettype none

// far node: clear-to-send line, baud ticks, shifter finish
module remote_node_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       hold_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       tx_load_i,
  output logic            cts_n_o,
  output logic            baud_tick_o,
  output logic            tx_char_done_o
);
  logic [1:0] div;
  logic [3:0] left;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div <= 2'h0;
      left <= 4'h0;
      cts_n_o <= 1'b0;
    end else begin
      div <= div + 2'h1;
      cts_n_o <= hold_i;
      if (tx_load_i)
        left <= delay_i;
      else if (left != 4'h0)
        left <= left - 4'h1;
    end
  end

  assign baud_tick_o = (div == 2'h3);
  assign tx_char_done_o = (left == 4'h1);
endmodule // remote_node_model

`default_nettype wire

// ### bench/test_usart_mode_flow_guard_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_usart_mode_flow_guard_control;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic        rx_data_ready_i = 1'b0;
  logic        rx_room_i = 1'b0;
  logic        tx_empty_i = 1'b0;
  logic        hold = 1'b0;
  logic [3:0]  dly = 4'h6;
  logic [31:0] rdata_o;
  logic        irq_o, rx_dma_req_o, tx_dma_req_o, rts_n_o, tx_load_o;
  logic        tx_complete_o, card_nak_o, infrared_enable_o;
  logic        infrared_low_power_o, half_duplex_o, card_mode_o;
  logic        single_sample_o, low_power_tick_o, card_clk_o;
  logic        unit_active_o, cts_n_i, baud_tick_i, tx_char_done_i;
  int          num_errors = 0;
  int          checked = 0;
  int          loads = 0;
  int          naks = 0;
  int          ticks = 0;
  int          bt = 0;
  int          n, m;

  always #50 clk_i = ~clk_i;

  usart_mode_flow_guard_control dut_u (
    .clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .framing_error_i(ev[0]), .overrun_error_i(ev[1]),
    .noise_error_i(ev[2]), .parity_error_i(ev[3]), .rx_data_ready_i,
    .rx_room_i, .tx_empty_i, .tx_write_i(ev[4]), .tx_char_done_i,
    .baud_tick_i, .cts_n_i, .irq_o, .rx_dma_req_o, .tx_dma_req_o,
    .rts_n_o, .tx_load_o, .tx_complete_o, .card_nak_o,
    .infrared_enable_o, .infrared_low_power_o, .half_duplex_o,
    .card_mode_o, .single_sample_o, .low_power_tick_o, .card_clk_o,
    .unit_active_o
  );

  remote_node_model peer_u (
    .clk_i, .reset_i, .hold_i(hold), .delay_i(dly),
    .tx_load_i(tx_load_o), .cts_n_o(cts_n_i),
    .baud_tick_o(baud_tick_i), .tx_char_done_o(tx_char_done_i)
  );

  // pulse counts, taken one edge late
  always @(posedge clk_i) begin
    loads += tx_load_o;
    naks += card_nak_o;
    ticks += low_power_tick_o;
    if (tx_char_done_i)
      bt = 0;
    else if (baud_tick_i)
      bt++;
  end

  task stop_test();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask

  task pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: return tx_load_o;
      1: return tx_complete_o;
      2: return card_nak_o;
      3: return low_power_tick_o;
      4: return card_clk_o;
      default: return !card_clk_o;
    endcase
  endfunction

  // cycles until the chosen output is high, bounded
  task waitf(input int w, output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (sel(w) !== 1'b1 && k < 300);
    if (sel(w) !== 1'b1) begin
      num_errors++;
      stop_test();
    end
  endtask

  task t_regs();
    chk(rts_n_o, 32'h1);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'hFFF);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'hFFFF);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    chk({card_mode_o, half_duplex_o, rts_n_o}, 32'h1);
    wr(8'h1C, 32'h1);
    cyc(2);
    chk({infrared_enable_o, infrared_low_power_o, half_duplex_o,
         card_mode_o, single_sample_o}, 32'h1F);
    wr(8'h14, 32'h0);
    rd(8'h14, 32'h800);
    wr(8'h1C, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    rd(8'h14, 32'h0);
    $display("register test done");
  endtask

  task t_errors();
    wr(8'h14, 32'h841);
    wr(8'h24, 32'h1F);
    wr(8'h1C, 32'h1);
    pulse(0);
    cyc(2);
    chk(irq_o, 32'h1);
    pulse(2);
    rd(8'h20, 32'h1);
    rx_data_ready_i <= 1'b1;
    cyc(3);
    chk({irq_o, rx_dma_req_o}, 32'h1);
    wr(8'h1C, 32'h0);
    wr(8'h14, 32'h081);
    wr(8'h1C, 32'h1);
    tx_empty_i <= 1'b1;
    pulse(1);
    pulse(2);
    cyc(2);
    chk({irq_o, rx_dma_req_o, tx_dma_req_o}, 32'h1);
    rd(8'h20, 32'h6);
    wr(8'h14, 32'h100);
    rx_room_i <= 1'b1;
    cyc(3);
    chk(rts_n_o, 32'h0);
    rx_room_i <= 1'b0;
    cyc(3);
    chk(rts_n_o, 32'h1);
    $display("error and flow test done");
  endtask

  task t_cts();
    wr(8'h14, 32'h600);
    rd(8'h20, 32'h0);
    hold <= 1'b1;
    cyc(3);
    chk(irq_o, 32'h1);
    pulse(4);
    cyc(10);
    chk(loads, 32'h0);
    hold <= 1'b0;
    waitf(0, n);
    chk(n < 5, 32'h1);
    waitf(1, n);
    rd(8'h20, 32'h18);
    wr(8'h14, 32'h200);
    hold <= 1'b1;
    cyc(3);
    chk(irq_o, 32'h0);
    hold <= 1'b0;
    dly <= 4'hC;
    pulse(4);
    waitf(0, n);
    hold <= 1'b1;
    waitf(1, n);
    chk(n < 16, 32'h1);
    pulse(4);
    cyc(12);
    chk(loads, 32'h2);
    hold <= 1'b0;
    waitf(0, n);
    waitf(1, n);
    $display("clear-to-send test done");
  endtask

  task t_card();
    wr(8'h18, 32'h300);
    wr(8'h14, 32'h030);
    pulse(4);
    waitf(0, n);
    waitf(1, n);
    chk(bt, 32'h3);
    pulse(3);
    cyc(0);
    chk(card_nak_o, 32'h1);
    wr(8'h14, 32'h020);
    pulse(3);
    cyc(4);
    chk(naks, 32'h1);
    wr(8'h18, 32'h0E2);
    waitf(4, n);
    waitf(5, n);
    waitf(4, m);
    chk(n + m, 32'h4);
    $display("card test done");
  endtask

  task t_prescale();
    wr(8'h14, 32'h006);
    wr(8'h18, 32'h003);
    waitf(3, n);
    waitf(3, n);
    chk(n, 32'h3);
    wr(8'h14, 32'h002);
    wr(8'h18, 32'h001);
    m = ticks;
    cyc(20);
    chk(ticks - m, 32'h0);
    chk({infrared_enable_o, infrared_low_power_o}, 32'h2);
    wr(8'h14, 32'h006);
    wr(8'h18, 32'h0FF);
    waitf(3, n);
    waitf(3, n);
    chk(n, 32'hFF);
    wr(8'h1C, 32'h0);
    cyc(2);
    m = ticks;
    cyc(300);
    chk(ticks - m, 32'h0);
    chk({unit_active_o, infrared_enable_o, rts_n_o}, 32'h1);
    $display("prescaler test done");
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    cyc(1);
    t_regs();
    t_errors();
    t_cts();
    t_card();
    t_prescale();
    stop_test();
  end
endmodule // test_usart_mode_flow_guard_control

`default_nettype wire
